// ---- src/acp_coproc.sv ----
`timescale 1ns/10ps
module acp_coproc #(
  parameter int OP_W = 16,
  parameter int ACC_W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction transfers from the core
  input wire logic coproc_mode_write,
  input wire logic [7:0] mode_value,
  input wire logic coproc_execute_load,
  input wire logic coproc_preset_load,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  // answer to the core
  output logic result_valid,
  output logic [15:0] result_data,
  output logic [3:0] carry_ovf_zero_neg_flags,
  // status
  output logic [7:0] current_mode,
  output logic overflow_sticky,
  output logic [15:0] term_count,
  output logic unsupported_mode
);

  acp_pkg::acp_state_s state_q;
  acp_pkg::acp_state_s state_d;
  acp_pkg::acp_req_s req;

  logic mac_signed;
  logic [31:0] mac_sum;
  logic mac_ovf;

  // decode helpers
  function automatic logic is_readout(input logic [7:0] m);
    is_readout = (m == acp_pkg::MODE_READ_PRIMARY_RESULT_REG_LO) ||
      (m == acp_pkg::MODE_READ_PRIMARY_RESULT_REG_HI) ||
      (m == acp_pkg::MODE_READ_SECONDARY_RESULT_REG_LO) ||
      (m == acp_pkg::MODE_READ_SECONDARY_RESULT_REG_HI);
  endfunction : is_readout

  function automatic logic is_mac(input logic [7:0] m);
    is_mac = (m == acp_pkg::MODE_MAC_U_LO) ||
      (m == acp_pkg::MODE_MAC_S_LO) ||
      (m == acp_pkg::MODE_MAC_U_HI) ||
      (m == acp_pkg::MODE_MAC_S_HI);
  endfunction : is_mac

  function automatic logic is_init(input logic [7:0] m);
    is_init = (m == acp_pkg::MODE_INIT_CLEAR) ||
      (m == acp_pkg::MODE_INIT_LOAD16) ||
      (m == acp_pkg::MODE_INIT_LOAD32);
  endfunction : is_init

  function automatic logic is_signed_mac(input logic [7:0] m);
    is_signed_mac = (m == acp_pkg::MODE_MAC_S_LO) ||
      (m == acp_pkg::MODE_MAC_S_HI);
  endfunction : is_signed_mac

  function automatic logic is_high_out(input logic [7:0] m);
    is_high_out = (m == acp_pkg::MODE_MAC_U_HI) ||
      (m == acp_pkg::MODE_MAC_S_HI);
  endfunction : is_high_out

  function automatic logic [15:0] pick_half(input logic [31:0] r,
                                            input logic hi);
    if (hi) begin
      pick_half = r[31:16];
    end else begin
      pick_half = r[15:0];
    end
  endfunction : pick_half

  // bundle the core's transfer
  always_comb begin
    req.mode_write = coproc_mode_write;
    req.mode_value = mode_value;
    req.execute_load = coproc_execute_load;
    req.preset_load = coproc_preset_load;
    req.operand_a = operand_a;
    req.operand_b = operand_b;
  end

  assign mac_signed = is_signed_mac(state_q.mode);

  acp_mac #(
    .OP_W(OP_W),
    .ACC_W(ACC_W)
  ) u_mac (
    .signed_mode(mac_signed),
    .multiplicand(req.operand_a),
    .multiplier(req.operand_b),
    .acc(state_q.primary_result_reg),
    .sum(mac_sum),
    .overflow(mac_ovf)
  );

  always_comb begin
    state_d = state_q;
    state_d.rsp.valid = 1'b0;

    // loads act on the mode already in force
    if (req.execute_load) begin
      state_d.rsp.valid = 1'b1;
      state_d.rsp.flags = acp_pkg::FLAGS_CLEAR;
      if (is_mac(state_q.mode)) begin
        if (mac_ovf) begin
          state_d.rsp.flags = acp_pkg::FLAGS_OVERFLOW;
          state_d.ovf = 1'b1;
          // a repeated overflow leaves the held result alone
          if (!state_q.ovf) begin
            state_d.primary_result_reg = mac_sum;
            state_d.terms = state_q.terms + acp_pkg::TERM_ONE;
          end else begin
            state_d.primary_result_reg = state_q.primary_result_reg;
          end
        end else begin
          state_d.primary_result_reg = mac_sum;
          state_d.ovf = 1'b0;
          state_d.terms = state_q.terms + acp_pkg::TERM_ONE;
        end
        state_d.rsp.data = pick_half(state_d.primary_result_reg,
          is_high_out(state_q.mode));
      end else if (is_readout(state_q.mode)) begin
        // readout leaves both registers and the sticky flag as they are
        case (state_q.mode)
          acp_pkg::MODE_READ_PRIMARY_RESULT_REG_LO: begin
            state_d.rsp.data = pick_half(state_q.primary_result_reg, 1'b0);
          end
          acp_pkg::MODE_READ_PRIMARY_RESULT_REG_HI: begin
            state_d.rsp.data = pick_half(state_q.primary_result_reg, 1'b1);
          end
          acp_pkg::MODE_READ_SECONDARY_RESULT_REG_LO: begin
            state_d.rsp.data = pick_half(state_q.secondary_result_reg, 1'b0);
          end
          acp_pkg::MODE_READ_SECONDARY_RESULT_REG_HI: begin
            state_d.rsp.data = pick_half(state_q.secondary_result_reg, 1'b1);
          end
          default: begin
            state_d.rsp.data = acp_pkg::DATA_RESET;
          end
        endcase
        state_d.rsp.flags = acp_pkg::FLAGS_CLEAR;
      end else begin
        // other modes return the low half and keep the registers
        state_d.rsp.data = pick_half(state_q.primary_result_reg, 1'b0);
        state_d.ovf = 1'b0;
      end
    end else if (req.preset_load) begin
      case (state_q.mode)
        acp_pkg::MODE_INIT_LOAD16: begin
          state_d.primary_result_reg = {acp_pkg::UPPER_ZERO, req.operand_b};
          state_d.terms = acp_pkg::TERM_RESET;
        end
        acp_pkg::MODE_INIT_LOAD32: begin
          state_d.primary_result_reg = {req.operand_a, req.operand_b};
          state_d.terms = acp_pkg::TERM_RESET;
        end
        default: begin
          state_d.primary_result_reg = state_q.primary_result_reg;
        end
      endcase
      if (!is_readout(state_q.mode)) begin
        state_d.ovf = 1'b0;
      end
    end

    // mode write takes effect for the following transfer
    if (req.mode_write) begin
      state_d.mode = req.mode_value;
      state_d.bad_mode = !(is_init(req.mode_value) ||
        is_mac(req.mode_value) || is_readout(req.mode_value));
      if (req.mode_value == acp_pkg::MODE_INIT_CLEAR) begin
        state_d.primary_result_reg = acp_pkg::RESULT_RESET;
        state_d.secondary_result_reg = acp_pkg::RESULT_RESET;
        state_d.terms = acp_pkg::TERM_RESET;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q.mode <= acp_pkg::MODE_RESET;
      state_q.primary_result_reg <= acp_pkg::RESULT_RESET;
      state_q.secondary_result_reg <= acp_pkg::RESULT_RESET;
      state_q.ovf <= 1'b0;
      state_q.terms <= acp_pkg::TERM_RESET;
      state_q.bad_mode <= 1'b0;
      state_q.rsp.valid <= 1'b0;
      state_q.rsp.data <= acp_pkg::DATA_RESET;
      state_q.rsp.flags <= acp_pkg::FLAGS_CLEAR;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign result_valid = state_q.rsp.valid;
  assign result_data = state_q.rsp.data;
  assign carry_ovf_zero_neg_flags = state_q.rsp.flags;
  assign current_mode = state_q.mode;
  assign overflow_sticky = state_q.ovf;
  assign term_count = state_q.terms;
  assign unsupported_mode = state_q.bad_mode;

endmodule : acp_coproc

// ---- inc/acp_pkg.sv ----
package acp_pkg;

  // operand, accumulator, mode and term-count widths
  localparam int OPERAND_W = 16;
  localparam int ACC_W = 32;
  localparam int MODE_W = 8;
  localparam int TERM_W = 16;

  // operating mode values
  localparam logic [7:0] MODE_INIT_CLEAR = 8'h00;
  localparam logic [7:0] MODE_INIT_LOAD16 = 8'h01;
  localparam logic [7:0] MODE_INIT_LOAD32 = 8'h02;
  localparam logic [7:0] MODE_READ_PRIMARY_RESULT_REG_LO = 8'h03;
  localparam logic [7:0] MODE_READ_PRIMARY_RESULT_REG_HI = 8'h13;
  localparam logic [7:0] MODE_READ_SECONDARY_RESULT_REG_LO = 8'h23;
  localparam logic [7:0] MODE_READ_SECONDARY_RESULT_REG_HI = 8'h33;
  localparam logic [7:0] MODE_MAC_U_LO = 8'h06;
  localparam logic [7:0] MODE_MAC_S_LO = 8'h07;
  localparam logic [7:0] MODE_MAC_U_HI = 8'h16;
  localparam logic [7:0] MODE_MAC_S_HI = 8'h17;

  // values after reset, the term increment and the upper-half fill
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] TERM_RESET = 16'h0000;
  localparam logic [15:0] TERM_ONE = 16'h0001;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;

  // carry, overflow, zero, negative as returned to the core
  typedef struct packed {
    logic c;
    logic v;
    logic z;
    logic n;
  } acp_flags_s;

  localparam acp_flags_s FLAGS_CLEAR = 4'h0;
  localparam acp_flags_s FLAGS_OVERFLOW = 4'h4;

  // one instruction transfer from the core
  typedef struct packed {
    logic mode_write;
    logic [7:0] mode_value;
    logic execute_load;
    logic preset_load;
    logic [15:0] operand_a;
    logic [15:0] operand_b;
  } acp_req_s;

  // answer to an execute-load
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    acp_flags_s flags;
  } acp_rsp_s;

  typedef struct packed {
    logic [7:0] mode;
    logic [31:0] primary_result_reg;
    logic [31:0] secondary_result_reg;
    logic ovf;
    logic [15:0] terms;
    logic bad_mode;
    acp_rsp_s rsp;
  } acp_state_s;

endpackage : acp_pkg

// ---- src/acp_mac.sv ----
`timescale 1ns/10ps
module acp_mac #(
  parameter int OP_W = 16,
  parameter int ACC_W = 32
) (
  // control
  input wire logic signed_mode,
  // operands
  input wire logic [OP_W-1:0] multiplicand,
  input wire logic [OP_W-1:0] multiplier,
  input wire logic [ACC_W-1:0] acc,
  // results
  output logic [ACC_W-1:0] sum,
  output logic overflow
);

  logic [ACC_W-1:0] ext_a;
  logic [ACC_W-1:0] ext_b;
  logic [ACC_W-1:0] prod;

  // extended operands keep the low product bits exact in both modes
  always_comb begin
    if (signed_mode) begin
      ext_a = {{(ACC_W-OP_W){multiplicand[OP_W-1]}}, multiplicand};
      ext_b = {{(ACC_W-OP_W){multiplier[OP_W-1]}}, multiplier};
    end else begin
      ext_a = {{(ACC_W-OP_W){1'b0}}, multiplicand};
      ext_b = {{(ACC_W-OP_W){1'b0}}, multiplier};
    end
    prod = ext_a * ext_b;
    sum = prod + acc;
    overflow = signed_mode & (prod[ACC_W-1] == acc[ACC_W-1]) &
      (sum[ACC_W-1] != acc[ACC_W-1]);
  end

endmodule : acp_mac

// ---- sim/acp_coproc_properties.sv ----
`timescale 1ns/10ps
module acp_coproc_properties (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // transfers
  input wire logic coproc_mode_write,
  input wire logic [7:0] mode_value,
  input wire logic coproc_execute_load,
  input wire logic coproc_preset_load,
  input wire logic [15:0] operand_a,
  input wire logic [15:0] operand_b,
  // answer and status
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic [3:0] carry_ovf_zero_neg_flags,
  input wire logic [7:0] current_mode,
  input wire logic overflow_sticky,
  input wire logic [15:0] term_count,
  input wire logic unsupported_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic ex, rd, sm, um;
  assign ex = coproc_execute_load;
  assign rd = current_mode inside {8'h03, 8'h13, 8'h23, 8'h33};
  assign sm = current_mode inside {8'h07, 8'h17};
  assign um = current_mode inside {8'h06, 8'h16};
  property p_answer;
    ex |=> result_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_only;
    result_valid |-> $past(ex);
  endproperty
  a_only: assert property (p_only) else $error("stray answer");
  property p_mode;
    coproc_mode_write |=> current_mode == $past(mode_value);
  endproperty
  a_mode: assert property (p_mode) else $error("mode lost");
  property p_rd;
    ex && rd |=> carry_ovf_zero_neg_flags == 4'h0 &&
      overflow_sticky == $past(overflow_sticky);
  endproperty
  a_rd: assert property (p_rd) else $error("readout flags");
  property p_umac;
    ex && um |=> carry_ovf_zero_neg_flags == 4'h0 && !overflow_sticky;
  endproperty
  a_umac: assert property (p_umac) else $error("unsigned flags");
  property p_smac;
    ex && sm |=> carry_ovf_zero_neg_flags == {1'b0, overflow_sticky, 2'b00};
  endproperty
  a_smac: assert property (p_smac) else $error("signed flags");
  property p_clr;
    (ex || coproc_preset_load) && !rd && !sm |=> !overflow_sticky;
  endproperty
  a_clr: assert property (p_clr) else $error("overflow kept");
  property p_init;
    coproc_mode_write && mode_value == 8'h00 |=> term_count == 16'h0000;
  endproperty
  a_init: assert property (p_init) else $error("clear missed");
  property p_hold;
    !(ex || coproc_preset_load || coproc_mode_write) |=>
      $stable(result_data) && $stable(overflow_sticky);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved");
  c_ovf: cover property (ex && sm ##1 carry_ovf_zero_neg_flags == 4'h4);
  c_rd: cover property (ex && rd);
  c_clr: cover property (coproc_mode_write && mode_value == 8'h00);
endmodule : acp_coproc_properties

bind acp_coproc acp_coproc_properties acp_coproc_properties_inst (
  .clk(clk),
  .resetn(resetn),
  .coproc_mode_write(coproc_mode_write),
  .mode_value(mode_value),
  .coproc_execute_load(coproc_execute_load),
  .coproc_preset_load(coproc_preset_load),
  .operand_a(operand_a),
  .operand_b(operand_b),
  .result_valid(result_valid),
  .result_data(result_data),
  .carry_ovf_zero_neg_flags(carry_ovf_zero_neg_flags),
  .current_mode(current_mode),
  .overflow_sticky(overflow_sticky),
  .term_count(term_count),
  .unsupported_mode(unsupported_mode)
);

// ---- sim/acp_cpu.sv ----
`timescale 1ns/10ps
module acp_cpu (
  // clock
  input wire logic clk,
  // transfers
  output logic coproc_mode_write,
  output logic [7:0] mode_value,
  output logic coproc_execute_load,
  output logic coproc_preset_load,
  output logic [15:0] operand_a,
  output logic [15:0] operand_b,
  // answer
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  input wire logic [3:0] carry_ovf_zero_neg_flags
);
  initial begin
    {coproc_mode_write, coproc_execute_load, coproc_preset_load} = 3'h0;
    mode_value = 8'h00;
    {operand_a, operand_b} = 32'h0;
  end
  // idle buses show the inverse of the last value
  task automatic mw(input logic [7:0] v);
    @(negedge clk);
    mode_value = v;
    coproc_mode_write = 1'b1;
    @(negedge clk);
    coproc_mode_write = 1'b0;
    mode_value = ~v;
  endtask : mw
  task automatic pl(input logic [15:0] a, input logic [15:0] b);
    @(negedge clk);
    {operand_a, operand_b} = {a, b};
    coproc_preset_load = 1'b1;
    @(negedge clk);
    coproc_preset_load = 1'b0;
    {operand_a, operand_b} = ~{a, b};
  endtask : pl
  task automatic ex(input logic [15:0] a, input logic [15:0] b,
                    output logic [15:0] d, output logic [3:0] f);
    int n;
    @(negedge clk);
    {operand_a, operand_b} = {a, b};
    coproc_execute_load = 1'b1;
    @(negedge clk);
    coproc_execute_load = 1'b0;
    {operand_a, operand_b} = ~{a, b};
    n = 0;
    while (result_valid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (result_valid === 1'b1) ? result_data : 16'hxxxx;
    f = carry_ovf_zero_neg_flags;
  endtask : ex
endmodule : acp_cpu

// ---- sim/test_coprocessor_mac_result_read.sv ----
`timescale 1ns/10ps
module test_coprocessor_mac_result_read;
  logic clk, resetn, result_valid, overflow_sticky, unsupported_mode;
  logic coproc_mode_write, coproc_execute_load, coproc_preset_load;
  logic [7:0] mode_value, current_mode;
  logic [15:0] operand_a, operand_b, result_data, term_count, d;
  logic [3:0] carry_ovf_zero_neg_flags, f;
  int n_mismatch = 0;
  int comparisons = 0;

  acp_coproc acp_coproc_inst (
    .clk(clk),
    .resetn(resetn),
    .coproc_mode_write(coproc_mode_write),
    .mode_value(mode_value),
    .coproc_execute_load(coproc_execute_load),
    .coproc_preset_load(coproc_preset_load),
    .operand_a(operand_a),
    .operand_b(operand_b),
    .result_valid(result_valid),
    .result_data(result_data),
    .carry_ovf_zero_neg_flags(carry_ovf_zero_neg_flags),
    .current_mode(current_mode),
    .overflow_sticky(overflow_sticky),
    .term_count(term_count),
    .unsupported_mode(unsupported_mode)
  );
  acp_cpu acp_cpu_inst (
    .clk(clk),
    .coproc_mode_write(coproc_mode_write),
    .mode_value(mode_value),
    .coproc_execute_load(coproc_execute_load),
    .coproc_preset_load(coproc_preset_load),
    .operand_a(operand_a),
    .operand_b(operand_b),
    .result_valid(result_valid),
    .result_data(result_data),
    .carry_ovf_zero_neg_flags(carry_ovf_zero_neg_flags)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic exq(input logic [15:0] a, b, e, input logic [3:0] ef);
    acp_cpu_inst.ex(a, b, d, f);
    chk(d, e);
    chk({12'h000, f}, {12'h000, ef});
  endtask : exq

  task automatic s_init;
    acp_cpu_inst.mw(8'h02);
    acp_cpu_inst.pl(16'h1234, 16'h5678);
    acp_cpu_inst.mw(8'h03);
    exq(16'h5a5a, 16'ha5a5, 16'h5678, 4'h0);
    acp_cpu_inst.mw(8'h13);
    exq(16'h0000, 16'h0000, 16'h1234, 4'h0);
    acp_cpu_inst.mw(8'h01);
    acp_cpu_inst.pl(16'hffff, 16'habcd);
    acp_cpu_inst.mw(8'h13);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
    acp_cpu_inst.mw(8'h03);
    exq(16'h0000, 16'h0000, 16'habcd, 4'h0);
    acp_cpu_inst.mw(8'h23);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
    acp_cpu_inst.mw(8'h33);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
    acp_cpu_inst.mw(8'h00);
    acp_cpu_inst.mw(8'h23);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
    acp_cpu_inst.mw(8'h33);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
    acp_cpu_inst.mw(8'h03);
    exq(16'h0000, 16'h0000, 16'h0000, 4'h0);
  endtask : s_init

  task automatic s_umac;
    acp_cpu_inst.mw(8'h02);
    acp_cpu_inst.pl(16'hffff, 16'hffff);
    acp_cpu_inst.mw(8'h06);
    exq(16'h0002, 16'h0003, 16'h0005, 4'h0);
    acp_cpu_inst.mw(8'h16);
    exq(16'hffff, 16'hffff, 16'hfffe, 4'h0);
    acp_cpu_inst.mw(8'h03);
    exq(16'h0000, 16'h0000, 16'h0006, 4'h0);
    chk(term_count, 16'h0002);
    acp_cpu_inst.mw(8'h05);
    chk({15'h0000, unsupported_mode}, 16'h0001);
    exq(16'h1111, 16'h2222, 16'h0006, 4'h0);
  endtask : s_umac

  task automatic s_smac;
    acp_cpu_inst.mw(8'h00);
    chk({15'h0000, unsupported_mode}, 16'h0000);
    acp_cpu_inst.mw(8'h07);
    exq(16'hffff, 16'h0002, 16'hfffe, 4'h0);
    acp_cpu_inst.mw(8'h02);
    acp_cpu_inst.pl(16'h7fff, 16'hfff0);
    acp_cpu_inst.mw(8'h07);
    exq(16'h0001, 16'h0020, 16'h0010, 4'h4);
    exq(16'h8000, 16'h7fff, 16'h0010, 4'h4);
    exq(16'h0000, 16'h0000, 16'h0010, 4'h0);
    acp_cpu_inst.mw(8'h17);
    exq(16'h0001, 16'h0001, 16'h8000, 4'h0);
    acp_cpu_inst.mw(8'h07);
    exq(16'h7fff, 16'h8000, 16'h8011, 4'h4);
    acp_cpu_inst.mw(8'h03);
    exq(16'h0000, 16'h0000, 16'h8011, 4'h0);
    acp_cpu_inst.mw(8'h13);
    exq(16'h0000, 16'h0000, 16'h4000, 4'h0);
    chk({15'h0, overflow_sticky}, 16'h0001);
    acp_cpu_inst.mw(8'h01);
    acp_cpu_inst.pl(16'h0000, 16'h0042);
    chk({15'h0, overflow_sticky}, 16'h0000);
  endtask : s_smac

  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude

  initial begin
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    s_init;
    s_umac;
    s_smac;
    conclude;
  end

  initial begin
    #20000;
    n_mismatch++;
    conclude;
  end
endmodule : test_coprocessor_mac_result_read
